// ### core/reader_byte_fifo.sv
// 24-byte circular fifo between the host link and the tx/rx framing logic
// assumes host accesses and commands arrive decoded on this clock, and that
// the framing logic is on the same clock, so no input needs synchronising
//
// What this block does
// - circular 24-byte store, write wraps 23 to 0
// - clear command empties fifo, zeroes pointers
// - input counter counts every byte loaded
// - output counter counts every byte taken out
// - both counters are twelve bits wide
// - request interrupt below six in transmit or above eighteen in receive
// - never pass more bytes than tx length
// - flag transmitter when final byte leaves fifo
// - status register shows current byte count
// - overflow flag on byte arriving when full
// - low flag set on low fill during transmit
// - high flag set on high fill during receive
// - data port reached only in continuous mode
`timescale 1ns/1ps
`include "reader_fifo_params.svh"

module reader_byte_fifo #(
    parameter int DEPTH = `FIFO_DEPTH,      // byte locations
    parameter int CW    = `FIFO_COUNT_WIDTH // counter width
) (
    input  wire logic                        clk,       // 10 MHz system clock
    input  wire logic                        reset_n,   // async reset, active low
    input  wire reader_fifo_pkg::reg_access_s access,   // decoded host access
    input  wire reader_fifo_pkg::command_s   command,   // decoded host command
    input  wire logic                        txMode,    // transmission in progress
    input  wire logic                        rxMode,    // reception in progress
    input  wire logic                        rxValid,   // framer delivers a byte
    input  wire logic [7:0]                  rxByte,    // received byte
    input  wire logic                        txTake,    // transmitter asks for a byte
    output logic      [7:0]                  rdData,    // host read data
    output logic                             rdValid,   // host read data strobe
    output logic      [7:0]                  txData,    // byte to transmitter
    output logic                             txValid,   // txData strobe
    output logic                             txLast,    // final byte of frame
    output logic                             fifoIrq    // fill level request
);

    localparam int AW = $clog2(DEPTH);      // pointer width

    // =================================================================
    // elaboration checks; the length packing needs at least nine counter bits
    if (DEPTH < 2 || DEPTH >= (1 << CW)) begin : g_bad_depth
        $error("reader_byte_fifo: depth does not suit counter width");
    end
    if (CW < 9 || CW > 16) begin : g_bad_width
        $error("reader_byte_fifo: counter width must be 9 to 16");
    end

    // =================================================================
    // state
    logic [CW-1:0] inCount;                 // bytes loaded since clear
    logic [CW-1:0] outCount;                // bytes taken since clear
    logic [AW-1:0] wrPtr;                   // next write location
    logic [AW-1:0] rdPtr;                   // next read location
    logic [CW-1:0] txLength;                // programmed byte count
    logic          overFlag;                // sticky overflow
    logic          lowFlag;                 // sticky low level in transmit
    logic          highFlag;                // sticky high level in receive
    logic          hostRdPend;              // host read in ram stage
    logic          hostRdFifo;              // pending port read takes a fifo byte
    logic [4:0]    hostRdAddr;              // pending read address
    logic          txPend;                  // tx byte in ram stage
    logic          txPendLast;              // that byte ends the frame
    logic [7:0]    ramQ;                    // registered ram data

    // =================================================================
    // decode: continuous mode is the only path to the data port
    wire           portHit    = access.cont && access.addr == `FIFO_DATA_ADDR;
    wire           clearCmd   = command.valid && command.code == `FIFO_CMD_CLEAR;
    wire           hostWrPort = access.write && portHit && txMode;
    wire           hostRdPort = access.read && portHit && !txMode;
    wire [CW-1:0]  fill       = inCount - outCount;
    wire           isFull     = fill >= CW'(DEPTH);
    wire           isEmpty    = fill == '0;
    // writes come from the host while sending, from the framer otherwise
    wire           wrReq      = txMode ? hostWrPort : rxValid;
    wire [7:0]     wrByte     = txMode ? access.data : rxByte;
    wire           wrOk       = wrReq && !isFull && !clearCmd;
    wire           overEvent  = wrReq && isFull;
    // tx may not pass the programmed length
    wire           txRoom     = outCount < txLength;
    wire           txOk       = txMode && txTake && !isEmpty && txRoom && !clearCmd;
    wire           txFinal    = (outCount + CW'(1)) == txLength;
    wire           hostRdOk   = hostRdPort && !isEmpty && !clearCmd;
    wire           rdOk       = txOk || hostRdOk;
    wire           lowLevel   = fill < CW'(`FIFO_LOW_LEVEL);
    wire           highLevel  = fill > CW'(`FIFO_HIGH_LEVEL);
    wire           lowEvent   = txMode && lowLevel;
    wire           highEvent  = rxMode && highLevel;
    wire [AW-1:0]  lastLoc    = AW'(DEPTH - 1);
    wire [AW-1:0]  next_wrPtr = (wrPtr == lastLoc) ? '0 : wrPtr + AW'(1);
    wire [AW-1:0]  next_rdPtr = (rdPtr == lastLoc) ? '0 : rdPtr + AW'(1);
    wire [4:0]     countField = (fill > CW'(31)) ? 5'h1F : fill[4:0];
    wire [7:0]     statusByte = {overFlag, highFlag, lowFlag, countField};
    wire [7:0]     regByte    = (hostRdAddr == `FIFO_STATUS_ADDR)   ? statusByte :
                                (hostRdAddr == `FIFO_TXLEN_HI_ADDR) ?
                                    8'(txLength >> 8) :
                                (hostRdAddr == `FIFO_TXLEN_LO_ADDR) ?
                                    txLength[7:0] : 8'h00;

    // =================================================================
    // byte store
    fifo_byte_ram #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) store (
        .clk    (clk),
        .wrEn   (wrOk),
        .wrAddr (wrPtr),
        .wrData (wrByte),
        .rdEn   (rdOk),
        .rdAddr (rdPtr),
        .rdData (ramQ)
    );

    // =================================================================
    // pointers and counters; clear wins over a same-cycle move
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inCount  <= `FIFO_COUNT_RESET;
            outCount <= `FIFO_COUNT_RESET;
            wrPtr    <= '0;
            rdPtr    <= '0;
        end else if (clearCmd) begin
            inCount  <= '0;
            outCount <= '0;
            wrPtr    <= '0;
            rdPtr    <= '0;
        end else begin
            if (wrOk) begin
                inCount <= inCount + CW'(1);
                wrPtr   <= next_wrPtr;
            end
            if (rdOk) begin
                outCount <= outCount + CW'(1);
                rdPtr    <= next_rdPtr;
            end
        end
    end

    // =================================================================
    // tx length, written by the host ahead of the data bytes
    // high register holds the top bits in its low nibble
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txLength <= `FIFO_TXLEN_RESET;
        end else if (access.write && access.addr == `FIFO_TXLEN_HI_ADDR) begin
            txLength <= {access.data[CW-9:0], txLength[7:0]};
        end else if (access.write && access.addr == `FIFO_TXLEN_LO_ADDR) begin
            txLength <= {txLength[CW-1:8], access.data};
        end
    end

    // =================================================================
    // sticky flags; an event in the clearing cycle still sets its flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overFlag <= 1'b0;
            lowFlag  <= 1'b0;
            highFlag <= 1'b0;
        end else begin
            overFlag <= overEvent || (overFlag && !clearCmd);
            lowFlag  <= lowEvent  || (lowFlag  && !clearCmd);
            highFlag <= highEvent || (highFlag && !clearCmd);
        end
    end

    // =================================================================
    // level request: live, not sticky, so refilling drops it by itself
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fifoIrq <= 1'b0;
        end else begin
            fifoIrq <= (txMode && lowLevel) || (rxMode && highLevel);
        end
    end

    // =================================================================
    // transmit path: ram data lines up with the strobe one cycle later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txPend     <= 1'b0;
            txPendLast <= 1'b0;
            txValid    <= 1'b0;
            txLast     <= 1'b0;
        end else begin
            txPend     <= txOk;
            txPendLast <= txOk && txFinal;
            txValid    <= txPend;
            txLast     <= txPendLast;
        end
    end

    // the byte must still be there when txValid shows, so it is held
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txData <= 8'h00;
        end else if (txPend) begin
            txData <= ramQ;
        end
    end

    // =================================================================
    // host read path, two cycles for every register alike
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hostRdPend <= 1'b0;
            hostRdFifo <= 1'b0;
            hostRdAddr <= 5'h00;
            rdValid    <= 1'b0;
            rdData     <= 8'h00;
        end else begin
            hostRdPend <= access.read;
            hostRdFifo <= hostRdOk;
            hostRdAddr <= access.addr;
            rdValid    <= hostRdPend;
            if (hostRdPend) begin
                // empty or single-mode port reads return zero
                rdData <= hostRdFifo ? ramQ : regByte;
            end
        end
    end

endmodule

// ### shared/reader_fifo_params.svh
// offsets, field positions, reset values and levels of the reader byte fifo
// assumes nothing; definitions only, included by bare name
`ifndef READER_FIFO_PARAMS_SVH
`define READER_FIFO_PARAMS_SVH

// =====================================================================
// register offsets
`define FIFO_TXLEN_HI_ADDR  5'h1D
`define FIFO_TXLEN_LO_ADDR  5'h1E
`define FIFO_DATA_ADDR      5'h1F
`define FIFO_STATUS_ADDR    5'h1C

// =====================================================================
// commands
`define FIFO_CMD_CLEAR      8'h0F

// =====================================================================
// geometry and levels
`define FIFO_DEPTH          24
`define FIFO_LOW_LEVEL      6
`define FIFO_HIGH_LEVEL     18
`define FIFO_COUNT_WIDTH    12

// =====================================================================
// status byte fields
`define FIFO_ST_COUNT_LSB   0
`define FIFO_ST_COUNT_MSB   4
`define FIFO_ST_LOW_BIT     5
`define FIFO_ST_HIGH_BIT    6
`define FIFO_ST_OVER_BIT    7

// =====================================================================
// reset values
`define FIFO_TXLEN_RESET    12'h000
`define FIFO_COUNT_RESET    12'h000

`endif

// ### shared/reader_fifo_pkg.sv
// types shared by the reader byte fifo and its neighbours
// assumes the register access arrives already decoded from the host link
package reader_fifo_pkg;

    // =================================================================
    // one decoded register access from the host interface logic
    typedef struct packed {
        logic       write;     // one-cycle write strobe
        logic       read;      // one-cycle read strobe
        logic       cont;      // access made in continuous address mode
        logic [4:0] addr;      // register address
        logic [7:0] data;      // write data
    } reg_access_s;

    // =================================================================
    // one command byte from the host interface logic
    typedef struct packed {
        logic       valid;     // one-cycle command strobe
        logic [7:0] code;      // command code
    } command_s;

endpackage

// ### core/fifo_byte_ram.sv
// small byte memory for the reader fifo, one write and one read port
// assumes the caller keeps both addresses below the depth
`timescale 1ns/1ps

module fifo_byte_ram #(
    parameter int DEPTH = 24,               // number of byte locations
    parameter int AW    = 5                 // address width
) (
    input  wire logic          clk,         // system clock
    input  wire logic          wrEn,        // write strobe
    input  wire logic [AW-1:0] wrAddr,      // write location
    input  wire logic [7:0]    wrData,      // write byte
    input  wire logic          rdEn,        // read strobe
    input  wire logic [AW-1:0] rdAddr,      // read location
    output logic      [7:0]    rdData       // registered read byte
);

    // =================================================================
    // storage
    logic [7:0] mem [DEPTH];                // byte array, no reset needed

    // refuse a depth that the address cannot reach
    if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_size
        $error("fifo_byte_ram: depth does not fit address width");
    end

    // =================================================================
    // write and registered read; data hold when no read
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// ### sim/reader_byte_fifo_checker.sv
// port assertions for the reader byte fifo
// assumes the reader_byte_fifo port list; bound after the module
`timescale 1ns/1ps
`include "reader_fifo_params.svh"

module reader_byte_fifo_checker #(
    parameter int DEPTH = 24,                            // byte locations
    parameter int CW    = 12                             // counter width
) (
    input wire logic                         clk,        // system clock
    input wire logic                         reset_n,    // async reset, low
    input wire reader_fifo_pkg::reg_access_s access,     // host access
    input wire reader_fifo_pkg::command_s    command,    // host command
    input wire logic                         txMode,     // transmit level
    input wire logic                         rxMode,     // receive level
    input wire logic                         rxValid,    // framer byte strobe
    input wire logic [7:0]                   rxByte,     // framer byte
    input wire logic                         txTake,     // transmitter request
    input wire logic [7:0]                   rdData,     // host read data
    input wire logic                         rdValid,    // host read strobe
    input wire logic [7:0]                   txData,     // byte to transmitter
    input wire logic                         txValid,    // txData strobe
    input wire logic                         txLast,     // final byte
    input wire logic                         fifoIrq     // fill request
);
    // =====================================================================
    // one clock domain, so defaults once
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // clear command accepted this cycle
    sequence s_clear;
        command.valid && command.code == `FIFO_CMD_CLEAR;
    endsequence

    // data port read in continuous mode
    wire portRead = access.read && access.cont && access.addr == `FIFO_DATA_ADDR;

    // =====================================================================
    // every read answers after exactly two cycles
    chk_read_answer: assert property (access.read |-> ##2 rdValid)
        else $error("read not answered");
    chk_answer_cause: assert property (rdValid |-> $past(access.read, 2))
        else $error("read answer without read");
    chk_tx_cause: assert property (txValid |-> $past(txTake, 2) && $past(txMode, 2))
        else $error("byte sent without request");
    chk_last_valid: assert property (txLast |-> txValid)
        else $error("last flag without byte");
    chk_irq_mode: assert property (fifoIrq |-> $past(txMode) || $past(rxMode))
        else $error("request outside a transfer");
    // empty after clear: low request in transmit, nothing to send or read
    chk_clear_irq: assert property (s_clear ##1 txMode |=> fifoIrq)
        else $error("no request after clear");
    chk_clear_empty: assert property (s_clear ##1 (txTake && txMode) |-> ##2 !txValid)
        else $error("byte sent after clear");
    chk_clear_read: assert property (s_clear ##1 (portRead && !txMode)
        |-> ##2 (rdValid && rdData == 8'h00))
        else $error("data read after clear");
    chk_tx_refuse: assert property ((txTake && !txMode) |-> ##2 !txValid)
        else $error("byte sent outside transmit");
endmodule

bind reader_byte_fifo reader_byte_fifo_checker #(.DEPTH(DEPTH), .CW(CW)) u_chk (
    .clk(clk), .reset_n(reset_n), .access(access), .command(command),
    .txMode(txMode), .rxMode(rxMode), .rxValid(rxValid), .rxByte(rxByte),
    .txTake(txTake), .rdData(rdData), .rdValid(rdValid), .txData(txData),
    .txValid(txValid), .txLast(txLast), .fifoIrq(fifoIrq));

// ### sim/framer_model.sv
// behavioural tx/rx framing logic beside the fifo
// assumes the caller is in step with clk; drives just after the edge
`timescale 1ns/1ps

module framer_model (
    input  wire logic       clk,      // system clock
    output logic            rxValid,  // byte strobe
    output logic      [7:0] rxByte,   // received byte
    output logic            txTake    // next byte request
);
    // =====================================================================
    // idle at time zero
    initial begin
        rxValid = 1'b0;
        rxByte  = 8'h00;
        txTake  = 1'b0;
    end

    // deliver one framed byte; stale byte inverted so it never looks valid
    task automatic push(input logic [7:0] b);
        @(posedge clk);
        #1 rxValid = 1'b1;
        rxByte = b;
        @(posedge clk);
        #1 rxValid = 1'b0;
        rxByte = ~b;
    endtask

    // ask for one byte to send
    task automatic take();
        @(posedge clk);
        #1 txTake = 1'b1;
        @(posedge clk);
        #1 txTake = 1'b0;
    endtask
endmodule

// ### sim/reader_byte_fifo_tb.sv
// self-checking bench for the reader byte fifo
// assumes the framer model and the bound checker
`timescale 1ns/1ps
`include "reader_fifo_params.svh"

module reader_byte_fifo_tb;
    logic                        clk;          // 10 MHz clock
    logic                        reset_n;      // async reset, low
    reader_fifo_pkg::reg_access_s access;      // host access
    reader_fifo_pkg::command_s   command;      // host command
    logic                        txMode;       // transmit level
    logic                        rxMode;       // receive level
    logic                        rxValid;      // framer strobe
    logic [7:0]                  rxByte;       // framer byte
    logic                        txTake;       // take request
    logic [7:0]                  rdData;       // read data
    logic                        rdValid;      // read strobe
    logic [7:0]                  txData;       // sent byte
    logic                        txValid;      // sent strobe
    logic                        txLast;       // final byte
    logic                        fifoIrq;      // fill request
    logic [8:0]                  txq[$];       // {last, byte} seen
    int                          mismatches;   // failed compares
    int                          comparisons;  // compares made
    int                          i;            // loop index

    reader_byte_fifo dut (.clk(clk), .reset_n(reset_n), .access(access),
        .command(command), .txMode(txMode), .rxMode(rxMode), .rxValid(rxValid),
        .rxByte(rxByte), .txTake(txTake), .rdData(rdData), .rdValid(rdValid),
        .txData(txData), .txValid(txValid), .txLast(txLast), .fifoIrq(fifoIrq));
    framer_model fm (.clk(clk), .rxValid(rxValid), .rxByte(rxByte), .txTake(txTake));

    // =====================================================================
    // clock and capture of sent bytes
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (txValid === 1'b1) txq.push_back({txLast, txData});

    // =====================================================================
    // compares and verdict
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    task automatic summarize();
        if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // =====================================================================
    // host access tasks, one strobe cycle each
    task automatic wr(input logic [4:0] a, input logic c, input logic [7:0] d);
        @(posedge clk);
        #1 access = '{1'b1, 1'b0, c, a, d};
        @(posedge clk);
        #1 access = '0;
    endtask
    task automatic rd(input logic [4:0] a, input logic c, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge clk);
        #1 access = '{1'b0, 1'b1, c, a, 8'h00};
        @(posedge clk);
        #1 access = '0;
        while (rdValid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1 n++;
        end
        // a missing answer must not pass on stale data
        chk1(rdValid, 1'b1);
        chk8(rdData, e);
    endtask
    task automatic clr();
        @(posedge clk);
        #1 command = '{1'b1, `FIFO_CMD_CLEAR};
        @(posedge clk);
        #1 command = '0;
    endtask

    // watchdog far beyond the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize();
    end

    // =====================================================================
    // main sequence
    initial begin
        access = '0;
        command = '0;
        txMode = 1'b0;
        rxMode = 1'b0;
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        // transmit: length 3, five bytes loaded, four takes
        txMode = 1'b1;
        fork clr(); begin @(posedge clk); fm.take(); end join
        wr(`FIFO_TXLEN_HI_ADDR, 1'b1, 8'hF5);
        rd(`FIFO_TXLEN_HI_ADDR, 1'b1, 8'h05);
        wr(`FIFO_TXLEN_HI_ADDR, 1'b1, 8'h00);
        wr(`FIFO_TXLEN_LO_ADDR, 1'b1, 8'h03);
        for (i = 0; i < 5; i++) wr(`FIFO_DATA_ADDR, 1'b1, 8'(8'h10 + i));
        wr(`FIFO_DATA_ADDR, 1'b0, 8'hEE);
        rd(`FIFO_STATUS_ADDR, 1'b0, 8'h25);
        chk1(fifoIrq, 1'b1);
        repeat (4) fm.take();
        repeat (3) @(posedge clk);
        chk8(8'(txq.size()), 8'h03);
        for (i = 0; i < 3; i++) chk8(txq[i][7:0], 8'(8'h10 + i));
        for (i = 0; i < 3; i++) chk1(txq[i][8], i == 2);
        rd(`FIFO_STATUS_ADDR, 1'b0, 8'h22);
        // receive: partial drain, write wrap, overflow, full drain
        txMode = 1'b0;
        rxMode = 1'b1;
        fork clr(); begin @(posedge clk); rd(`FIFO_DATA_ADDR, 1'b1, 8'h00); end join
        for (i = 0; i < 20; i++) fm.push(8'(8'h40 + i));
        rd(`FIFO_STATUS_ADDR, 1'b0, 8'h54);
        chk1(fifoIrq, 1'b1);
        for (i = 0; i < 10; i++) rd(`FIFO_DATA_ADDR, 1'b1, 8'(8'h40 + i));
        for (i = 20; i < 35; i++) fm.push(8'(8'h40 + i));
        rd(`FIFO_STATUS_ADDR, 1'b0, 8'hD8);
        for (i = 10; i < 34; i++) rd(`FIFO_DATA_ADDR, 1'b1, 8'(8'h40 + i));
        rd(`FIFO_STATUS_ADDR, 1'b0, 8'hC0);
        chk1(fifoIrq, 1'b0);
        rd(`FIFO_DATA_ADDR, 1'b1, 8'h00);
        rd(`FIFO_DATA_ADDR, 1'b0, 8'h00);
        rd(5'h00, 1'b0, 8'h00);
        // mid-run reset: sticky flags, length and request return to zero
        @(posedge clk);
        #1 reset_n = 1'b0;
        @(posedge clk);
        #1 reset_n = 1'b1;
        rd(`FIFO_STATUS_ADDR, 1'b0, 8'h00);
        rd(`FIFO_TXLEN_LO_ADDR, 1'b0, 8'h00);
        chk1(fifoIrq, 1'b0);
        fm.take();
        repeat (3) @(posedge clk);
        chk8(8'(txq.size()), 8'h03);
        summarize();
    end
endmodule
